// >>> lt_pkg.sv
package lt_pkg;
  // Special-function register addresses
  localparam logic [7:0] LT_ADDR_IRQ_STAT = 8'h85;
  localparam logic [7:0] LT_ADDR_CFG = 8'h93;
  localparam logic [7:0] LT_ADDR_SET_HIGH = 8'h94;
  localparam logic [7:0] LT_ADDR_SET_LOW = 8'h95;
  localparam logic [7:0] LT_ADDR_IEN_SECOND = 8'hE6;
  localparam logic [7:0] LT_ADDR_IPEND_SECOND = 8'hF1;
  localparam logic [7:0] LT_ADDR_IPRI_SECOND = 8'hF6;
  localparam logic [7:0] LT_ADDR_PWR_SWITCH = 8'hFE;
  // Secondary-bus address
  localparam logic [7:0] LT_ADDR_EXTERNAL_CRYSTAL_CLOCK_FREQ = 8'h1F;

  // Reset values
  localparam logic [7:0] LT_RST_ZERO = 8'h00;
  localparam logic [4:0] LT_RST_PWR_SWITCH = 5'h1F;

  // Field positions
  localparam int LT_CFG_ENABLE_BIT = 0;
  localparam int LT_CFG_RELOAD_BIT = 1;
  localparam int LT_CFG_CLKSEL_BIT = 2;
  localparam int LT_CFG_STEP_BIT = 3;
  localparam int LT_CFG_WIDTH = 4;
  localparam int LT_STAT_TIMER_BIT = 0;
  localparam int LT_STAT_WDOG_BIT = 1;
  localparam int LT_SHARED_IRQ_BIT = 7;
  localparam int LT_IRQ_REG_LOW_BIT = 2;
  localparam int LT_PWR_EXTERNAL_CRYSTAL_CLOCK_BIT = 2;
  localparam int LT_PWR_WIDTH = 5;
  localparam int LT_EXTERNAL_CRYSTAL_CLOCK_FREQ_BIT = 0;

  // Counter geometry
  localparam int LT_CNT_WIDTH = 32;
  localparam int LT_PRESCALE_WIDTH = 16;
  localparam logic [15:0] LT_PRESCALE_LAST = 16'hFFFF;
  localparam logic [31:0] LT_CNT_ONE = 32'h0000_0001;
  localparam logic [15:0] LT_PRESCALE_ONE = 16'h0001;
endpackage

// >>> lt_sync.sv
`timescale 1ns/1ps
// Two-flop level synchroniser
module lt_sync
  import lt_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;

  always_comb begin
    meta_nxt = d_i;
    q_nxt = meta_r;
    if (srst_i) begin
      meta_nxt = 1'b0;
      q_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    meta_r <= meta_nxt;
    q_r <= q_nxt;
  end

  assign q_o = q_r;
endmodule

// >>> lt_core.sv
`timescale 1ns/1ps
// Counter in the timer-clock domain; restart arrives as a toggle, other control as levels, done leaves as a toggle
module lt_core
  import lt_pkg::*;
(
  input wire logic tclk_i,
  input wire logic trst_i,
  // Control from system domain
  input wire logic run_i,
  input wire logic reload_i,
  input wire logic step_i,
  input wire logic restart_tgl_i,
  input wire logic [15:0] set_value_i,
  // Completion event
  output logic done_tgl_o
);
  logic run_s;
  logic reload_s;
  logic step_s;
  logic restart_s;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [15:0] pre_r;
  logic [15:0] pre_nxt;
  logic restart_seen_r;
  logic restart_seen_nxt;
  logic done_tgl_r;
  logic done_tgl_nxt;
  logic tick;
  logic hit;

  lt_sync u_sync_run (.clk_i(tclk_i), .srst_i(trst_i), .d_i(run_i), .q_o(run_s));
  lt_sync u_sync_rld (.clk_i(tclk_i), .srst_i(trst_i), .d_i(reload_i), .q_o(reload_s));
  lt_sync u_sync_step (.clk_i(tclk_i), .srst_i(trst_i), .d_i(step_i), .q_o(step_s));
  lt_sync u_sync_rst (.clk_i(tclk_i), .srst_i(trst_i), .d_i(restart_tgl_i), .q_o(restart_s));

  // Step is one clock or a full prescaler wrap
  assign tick = step_s ? (pre_r == LT_PRESCALE_LAST) : 1'b1;
  // Count runs 0..set, so duration is set+1 ticks
  assign hit = tick && (count_r == {16'h0000, set_value_i});

  always_comb begin
    count_nxt = count_r;
    pre_nxt = pre_r;
    restart_seen_nxt = restart_s;
    done_tgl_nxt = done_tgl_r;
    if (restart_s != restart_seen_r) begin
      count_nxt = '0;
      pre_nxt = '0;
    end else if (run_s) begin
      pre_nxt = pre_r + LT_PRESCALE_ONE;
      if (hit) begin
        done_tgl_nxt = ~done_tgl_r;
        count_nxt = '0;
      end else if (tick) begin
        count_nxt = count_r + LT_CNT_ONE;
      end
    end
    if (trst_i) begin
      count_nxt = '0;
      pre_nxt = '0;
      restart_seen_nxt = 1'b0;
      done_tgl_nxt = 1'b0;
    end
  end

  always_ff @(posedge tclk_i) begin
    count_r <= count_nxt;
    pre_r <= pre_nxt;
    restart_seen_r <= restart_seen_nxt;
    done_tgl_r <= done_tgl_nxt;
  end

  assign done_tgl_o = done_tgl_r;
  // Reload mode only matters on the system side, where one-shot drops the enable
  logic unused_reload;
  assign unused_reload = reload_s;
endmodule

// >>> lt_top.sv
`timescale 1ns/1ps
// Overview of operation
// - 32-bit up-counter counts timer ticks and flags completion at the set value.
// - Duration is one step (one or 65536 timer-clock periods) times set value plus one.
// - Writing set high, set low or config clears the counter.
// - Config bit 3 chooses step of one or 65536 timer clocks.
// - Config bit 2 picks crystal clock when set, internal RC otherwise.
// - Config bit 1 picks automatic reload, else one-shot.
// - Config bit 0 starts counting when 1, stops when 0.
// - One-shot completion clears the enable bit and halts counting, unless config is written in the same cycle.
// - Auto-reload completion keeps enable and restarts from zero.
// - Writing enable 1 while running restarts from zero.
// - Writing a set byte while running restarts the count.
// - Completion interrupt can wake the core from idle.
// - Status bit 0 sets on completion; cleared by writing 0 or config write.
// - Enable register bit 7 gates the shared interrupt.
// - Pending register bit 7 reads 1 while shared interrupt pending.
// - Priority register bit 7 selects low or high priority.
// - Power switch bit 2 turns crystal off when 1; off at reset.
// - Secondary register bit 0 selects 4 MHz crystal or 32768 Hz.
module lt_top
  import lt_pkg::*;
(
  // System clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Timer clocks, already chosen glitch-free outside by timer_clock_select
  input wire logic timer_clk_i,
  input wire logic timer_srst_i,
  // Special-function register port
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Secondary bus port
  input wire logic sec_wr_i,
  input wire logic [7:0] sec_addr_i,
  input wire logic [7:0] sec_wdata_i,
  output logic [7:0] sec_rdata_o,
  // Interrupt side
  input wire logic global_irq_enable_i,
  input wire logic watchdog_done_i,
  output logic irq_o,
  output logic irq_high_priority_o,
  output logic wake_o,
  // Clock and oscillator control
  output logic timer_clock_select_o,
  output logic crystal_power_down_o,
  output logic crystal_frequency_bit_o
);
  logic [3:0] cfg_r;
  logic [3:0] cfg_nxt;
  logic [7:0] set_high_r;
  logic [7:0] set_high_nxt;
  logic [7:0] set_low_r;
  logic [7:0] set_low_nxt;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [7:2] ien_r;
  logic [7:2] ien_nxt;
  logic [7:2] ipend_r;
  logic [7:2] ipend_nxt;
  logic [7:2] ipri_r;
  logic [7:2] ipri_nxt;
  logic [4:0] pwr_r;
  logic [4:0] pwr_nxt;
  logic xfreq_r;
  logic xfreq_nxt;
  logic restart_tgl_r;
  logic restart_tgl_nxt;
  logic done_seen_r;
  logic done_seen_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] sec_rdata_r;
  logic [7:0] sec_rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic wake_r;
  logic wake_nxt;
  logic done_tgl;
  logic done_s;
  logic done_evt;
  logic wr_cfg;
  logic wr_set;
  logic wr_stat;

  lt_core u_core (
    .tclk_i(timer_clk_i),
    .trst_i(timer_srst_i),
    .run_i(cfg_r[LT_CFG_ENABLE_BIT]),
    .reload_i(cfg_r[LT_CFG_RELOAD_BIT]),
    .step_i(cfg_r[LT_CFG_STEP_BIT]),
    .restart_tgl_i(restart_tgl_r),
    .set_value_i({set_high_r, set_low_r}),
    .done_tgl_o(done_tgl)
  );

  // Completion toggle crosses into system clock
  lt_sync u_sync_done (.clk_i(clk_i), .srst_i(srst_i), .d_i(done_tgl), .q_o(done_s));
  assign done_evt = done_s ^ done_seen_r;

  assign wr_cfg = sfr_wr_i && (sfr_addr_i == LT_ADDR_CFG);
  assign wr_set = sfr_wr_i && ((sfr_addr_i == LT_ADDR_SET_HIGH) || (sfr_addr_i == LT_ADDR_SET_LOW));
  assign wr_stat = sfr_wr_i && (sfr_addr_i == LT_ADDR_IRQ_STAT);

  always_comb begin
    cfg_nxt = cfg_r;
    set_high_nxt = set_high_r;
    set_low_nxt = set_low_r;
    stat_nxt = stat_r;
    ien_nxt = ien_r;
    ipend_nxt = ipend_r;
    ipri_nxt = ipri_r;
    pwr_nxt = pwr_r;
    xfreq_nxt = xfreq_r;
    restart_tgl_nxt = restart_tgl_r;
    done_seen_nxt = done_s;
    rdata_nxt = LT_RST_ZERO;
    sec_rdata_nxt = LT_RST_ZERO;

    if (sfr_wr_i) begin
      case (sfr_addr_i)
        LT_ADDR_CFG: cfg_nxt = sfr_wdata_i[LT_CFG_WIDTH-1:0];
        LT_ADDR_SET_HIGH: set_high_nxt = sfr_wdata_i;
        LT_ADDR_SET_LOW: set_low_nxt = sfr_wdata_i;
        LT_ADDR_IEN_SECOND: ien_nxt = sfr_wdata_i[7:LT_IRQ_REG_LOW_BIT];
        LT_ADDR_IPEND_SECOND: ipend_nxt = sfr_wdata_i[7:LT_IRQ_REG_LOW_BIT];
        LT_ADDR_IPRI_SECOND: ipri_nxt = sfr_wdata_i[7:LT_IRQ_REG_LOW_BIT];
        LT_ADDR_PWR_SWITCH: pwr_nxt = sfr_wdata_i[LT_PWR_WIDTH-1:0];
        default: ;
      endcase
    end
    // Any write to config or set bytes restarts the count from zero
    if (wr_cfg || wr_set) begin
      restart_tgl_nxt = ~restart_tgl_r;
    end
    // Status: write 0 clears, config write clears bit 0; a done in the same cycle wins
    if (wr_stat) begin
      stat_nxt = stat_r & sfr_wdata_i[1:0];
    end
    if (wr_cfg) begin
      stat_nxt[LT_STAT_TIMER_BIT] = 1'b0;
    end
    if (watchdog_done_i) begin
      stat_nxt[LT_STAT_WDOG_BIT] = 1'b1;
      ipend_nxt[LT_SHARED_IRQ_BIT] = 1'b1;
    end
    if (done_evt) begin
      stat_nxt[LT_STAT_TIMER_BIT] = 1'b1;
      ipend_nxt[LT_SHARED_IRQ_BIT] = 1'b1;
      if (!cfg_nxt[LT_CFG_RELOAD_BIT] && !wr_cfg) begin
        cfg_nxt[LT_CFG_ENABLE_BIT] = 1'b0;
      end
    end
    if (sec_wr_i && (sec_addr_i == LT_ADDR_EXTERNAL_CRYSTAL_CLOCK_FREQ)) begin
      xfreq_nxt = sec_wdata_i[LT_EXTERNAL_CRYSTAL_CLOCK_FREQ_BIT];
    end

    if (sfr_rd_i) begin
      case (sfr_addr_i)
        LT_ADDR_IRQ_STAT: rdata_nxt = {6'h00, stat_r};
        LT_ADDR_CFG: rdata_nxt = {4'h0, cfg_r};
        LT_ADDR_SET_HIGH: rdata_nxt = set_high_r;
        LT_ADDR_SET_LOW: rdata_nxt = set_low_r;
        LT_ADDR_IEN_SECOND: rdata_nxt = {ien_r, 2'b00};
        LT_ADDR_IPEND_SECOND: rdata_nxt = {ipend_r, 2'b00};
        LT_ADDR_IPRI_SECOND: rdata_nxt = {ipri_r, 2'b00};
        LT_ADDR_PWR_SWITCH: rdata_nxt = {3'h0, pwr_r};
        default: rdata_nxt = LT_RST_ZERO;
      endcase
    end
    if (sec_addr_i == LT_ADDR_EXTERNAL_CRYSTAL_CLOCK_FREQ) begin
      sec_rdata_nxt = {7'h00, xfreq_r};
    end

    // Shared request gated by its own and the global enable
    irq_nxt = ipend_r[LT_SHARED_IRQ_BIT] && ien_r[LT_SHARED_IRQ_BIT] && global_irq_enable_i;
    // Wake from idle on a pending enabled timer completion
    wake_nxt = stat_r[LT_STAT_TIMER_BIT] && ien_r[LT_SHARED_IRQ_BIT];

    if (srst_i) begin
      cfg_nxt = '0;
      set_high_nxt = LT_RST_ZERO;
      set_low_nxt = LT_RST_ZERO;
      stat_nxt = '0;
      ien_nxt = '0;
      ipend_nxt = '0;
      ipri_nxt = '0;
      pwr_nxt = LT_RST_PWR_SWITCH;
      xfreq_nxt = 1'b0;
      restart_tgl_nxt = 1'b0;
      done_seen_nxt = 1'b0;
      rdata_nxt = LT_RST_ZERO;
      sec_rdata_nxt = LT_RST_ZERO;
      irq_nxt = 1'b0;
      wake_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    cfg_r <= cfg_nxt;
    set_high_r <= set_high_nxt;
    set_low_r <= set_low_nxt;
    stat_r <= stat_nxt;
    ien_r <= ien_nxt;
    ipend_r <= ipend_nxt;
    ipri_r <= ipri_nxt;
    pwr_r <= pwr_nxt;
    xfreq_r <= xfreq_nxt;
    restart_tgl_r <= restart_tgl_nxt;
    done_seen_r <= done_seen_nxt;
    rdata_r <= rdata_nxt;
    sec_rdata_r <= sec_rdata_nxt;
    irq_r <= irq_nxt;
    wake_r <= wake_nxt;
  end

  assign sfr_rdata_o = rdata_r;
  assign sec_rdata_o = sec_rdata_r;
  assign irq_o = irq_r;
  assign irq_high_priority_o = ipri_r[LT_SHARED_IRQ_BIT];
  assign wake_o = wake_r;
  assign timer_clock_select_o = cfg_r[LT_CFG_CLKSEL_BIT];
  assign crystal_power_down_o = pwr_r[LT_PWR_EXTERNAL_CRYSTAL_CLOCK_BIT];
  assign crystal_frequency_bit_o = xfreq_r;
endmodule

// >>> lt_props.sv
`timescale 1ns/1ps
module lt_props
  import lt_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sec_wr_i,
  input wire logic [7:0] sec_addr_i,
  input wire logic [7:0] sec_wdata_i,
  input wire logic [7:0] sec_rdata_o,
  input wire logic global_irq_enable_i,
  input wire logic irq_o,
  input wire logic irq_high_priority_o,
  input wire logic wake_o,
  input wire logic timer_clock_select_o,
  input wire logic crystal_power_down_o,
  input wire logic crystal_frequency_bit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_glob; irq_o |-> $past(global_irq_enable_i); endproperty
  a_glob: assert property (p_glob) else $error("irq without global enable");
  property p_clk; sfr_wr_i && sfr_addr_i == LT_ADDR_CFG |=> timer_clock_select_o == $past(sfr_wdata_i[2]); endproperty
  a_clk: assert property (p_clk) else $error("clock select not taken");
  property p_pwr; sfr_wr_i && sfr_addr_i == LT_ADDR_PWR_SWITCH |=> crystal_power_down_o == $past(sfr_wdata_i[2]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("crystal power bit not taken");
  property p_pri; sfr_wr_i && sfr_addr_i == LT_ADDR_IPRI_SECOND |=> irq_high_priority_o == $past(sfr_wdata_i[7]);
  endproperty
  a_pri: assert property (p_pri) else $error("priority bit not taken");
  property p_xf; sec_wr_i && sec_addr_i == LT_ADDR_EXTERNAL_CRYSTAL_CLOCK_FREQ |=> crystal_frequency_bit_o == $past(sec_wdata_i[0]);
  endproperty
  a_xf: assert property (p_xf) else $error("crystal frequency bit not taken");
  property p_gate; sfr_wr_i && sfr_addr_i == LT_ADDR_IEN_SECOND && !sfr_wdata_i[7] |=> ##1 !irq_o && !wake_o;
  endproperty
  a_gate: assert property (p_gate) else $error("masked interrupt still active");
  property p_sec_rd; sec_addr_i == LT_ADDR_EXTERNAL_CRYSTAL_CLOCK_FREQ && !sec_wr_i |=> sec_rdata_o == {7'h00, crystal_frequency_bit_o};
  endproperty
  a_sec_rd: assert property (p_sec_rd) else $error("secondary read wrong");
  property p_stat_rd; sfr_rd_i && sfr_addr_i == LT_ADDR_IRQ_STAT |=> sfr_rdata_o[7:2] == 6'h00; endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status reserved bits set");
  property p_pwr_rd; sfr_rd_i && !sfr_wr_i && sfr_addr_i == LT_ADDR_PWR_SWITCH |=> sfr_rdata_o[2] == crystal_power_down_o;
  endproperty
  a_pwr_rd: assert property (p_pwr_rd) else $error("power read disagrees");
endmodule
bind lt_top lt_props lt_props_inst (.clk_i(clk_i), .srst_i(srst_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sec_wr_i(sec_wr_i),
  .sec_addr_i(sec_addr_i), .sec_wdata_i(sec_wdata_i), .sec_rdata_o(sec_rdata_o),
  .global_irq_enable_i(global_irq_enable_i), .irq_o(irq_o), .irq_high_priority_o(irq_high_priority_o),
  .wake_o(wake_o), .timer_clock_select_o(timer_clock_select_o), .crystal_power_down_o(crystal_power_down_o),
  .crystal_frequency_bit_o(crystal_frequency_bit_o));

// >>> lt_top_tb.sv
`timescale 1ns/1ps
module lt_top_tb;
  import lt_pkg::*;
  logic clk_i = 0, srst_i = 1, timer_clk_i = 0, timer_srst_i = 1, sfr_wr_i = 0, sfr_rd_i = 0, sec_wr_i = 0;
  logic global_irq_enable_i = 0, watchdog_done_i = 0, taken = 0;
  logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sec_addr_i = 0, sec_wdata_i = 0, sfr_rdata_o, sec_rdata_o, v, n;
  logic irq_o, irq_high_priority_o, wake_o, timer_clock_select_o, crystal_power_down_o, crystal_frequency_bit_o;
  logic [7:0] exp_q[$];
  logic [7:0] ra [9] = '{LT_ADDR_IRQ_STAT, LT_ADDR_CFG, LT_ADDR_SET_HIGH, LT_ADDR_SET_LOW, LT_ADDR_IEN_SECOND,
    LT_ADDR_IPEND_SECOND, LT_ADDR_IPRI_SECOND, LT_ADDR_PWR_SWITCH, 8'h80};
  int num_errors = 0, cmp_count = 0, seed = 38254;
  realtime t0;
  lt_top lt_top_inst (.clk_i(clk_i), .srst_i(srst_i), .timer_clk_i(timer_clk_i), .timer_srst_i(timer_srst_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .sec_wr_i(sec_wr_i), .sec_addr_i(sec_addr_i), .sec_wdata_i(sec_wdata_i),
    .sec_rdata_o(sec_rdata_o), .global_irq_enable_i(global_irq_enable_i), .watchdog_done_i(watchdog_done_i),
    .irq_o(irq_o), .irq_high_priority_o(irq_high_priority_o), .wake_o(wake_o),
    .timer_clock_select_o(timer_clock_select_o), .crystal_power_down_o(crystal_power_down_o),
    .crystal_frequency_bit_o(crystal_frequency_bit_o));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Timer clock kept out of phase with the bus clock
  initial begin
    #1.3;
    forever #3.5 timer_clk_i = ~timer_clk_i;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1;
    @(negedge clk_i);
    sfr_wr_i = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1;
    exp_q.push_back(e);
    @(negedge clk_i);
    sfr_rd_i = 0;
  endtask
  // Read data stands one cycle, so it is taken at the following falling edge
  always @(posedge clk_i) taken <= sfr_rd_i;
  always @(negedge clk_i) begin
    if (taken)
      check(sfr_rdata_o, exp_q.pop_front());
  end
  // Window allows for the two clock crossings on top of the count itself
  task wait_wake(input int lo);
    int k;
    realtime el;
    k = 0;
    @(negedge clk_i);
    while (wake_o !== 1'b1) begin
      @(negedge clk_i);
      k++;
      if (k > 400) begin
        num_errors++;
        wrap_up();
      end
    end
    el = $realtime - t0;
    if (lo > 0)
      check({7'h00, el >= lo && el <= lo + 100}, 8'h01);
  endtask
  initial begin
    repeat (3) @(negedge clk_i);
    srst_i = 0;
    timer_srst_i = 0;
    for (int i = 0; i < 9; i++) rd(ra[i], (i == 7) ? 8'h1F : 8'h00);
    v = $random(seed);
    sec_addr_i = LT_ADDR_EXTERNAL_CRYSTAL_CLOCK_FREQ;
    sec_wdata_i = v;
    sec_wr_i = 1;
    @(negedge clk_i);
    sec_wr_i = 0;
    @(negedge clk_i);
    check({7'h00, crystal_frequency_bit_o}, {7'h00, v[0]});
    check(sec_rdata_o, {7'h00, v[0]});
    wr(LT_ADDR_IPRI_SECOND, v);
    rd(LT_ADDR_IPRI_SECOND, v & 8'hFC);
    check({7'h00, irq_high_priority_o}, {7'h00, v[7]});
    wr(LT_ADDR_PWR_SWITCH, v);
    rd(LT_ADDR_PWR_SWITCH, v & 8'h1F);
    check({7'h00, crystal_power_down_o}, {7'h00, v[2]});
    wr(LT_ADDR_CFG, v & 8'h0E);
    rd(LT_ADDR_CFG, v & 8'h0E);
    check({7'h00, timer_clock_select_o}, {7'h00, v[2]});
    n = 8'h08 + ($random(seed) & 8'h0F);
    global_irq_enable_i = 1;
    wr(LT_ADDR_CFG, 8'h00);
    wr(LT_ADDR_IEN_SECOND, 8'h00);
    wr(LT_ADDR_SET_HIGH, 8'h00);
    wr(LT_ADDR_SET_LOW, n);
    wr(LT_ADDR_CFG, 8'h01);
    repeat (60) @(negedge clk_i);
    check({6'h00, irq_o, wake_o}, 8'h00);
    rd(LT_ADDR_CFG, 8'h00);
    rd(LT_ADDR_IRQ_STAT, 8'h01);
    rd(LT_ADDR_IPEND_SECOND, 8'h80);
    wr(LT_ADDR_IRQ_STAT, 8'h00);
    rd(LT_ADDR_IRQ_STAT, 8'h00);
    wr(LT_ADDR_IPEND_SECOND, 8'h00);
    wr(LT_ADDR_IEN_SECOND, 8'h80);
    wr(LT_ADDR_CFG, 8'h01);
    t0 = $realtime;
    wait_wake((n + 1) * 7);
    check({7'h00, irq_o}, 8'h01);
    rd(LT_ADDR_CFG, 8'h00);
    wr(LT_ADDR_CFG, 8'h00);
    rd(LT_ADDR_IRQ_STAT, 8'h00);
    wr(LT_ADDR_IPEND_SECOND, 8'h00);
    wr(LT_ADDR_CFG, 8'h03);
    // Restarts come closer together than the shortest count, so no early completion slips in
    repeat (2) @(negedge clk_i);
    wr(LT_ADDR_CFG, 8'h03);
    repeat (2) @(negedge clk_i);
    wr(LT_ADDR_SET_LOW, n);
    t0 = $realtime;
    wait_wake((n + 1) * 7);
    rd(LT_ADDR_CFG, 8'h03);
    wr(LT_ADDR_IRQ_STAT, 8'h00);
    wait_wake(0);
    rd(LT_ADDR_IRQ_STAT, 8'h01);
    wr(LT_ADDR_CFG, 8'h02);
    repeat (10) @(negedge clk_i);
    wr(LT_ADDR_IRQ_STAT, 8'h00);
    wr(LT_ADDR_IPEND_SECOND, 8'h00);
    wr(LT_ADDR_CFG, 8'h09);
    repeat (300) @(negedge clk_i);
    rd(LT_ADDR_IRQ_STAT, 8'h00);
    wr(LT_ADDR_CFG, 8'h00);
    watchdog_done_i = 1;
    @(negedge clk_i);
    watchdog_done_i = 0;
    repeat (4) @(negedge clk_i);
    rd(LT_ADDR_IRQ_STAT, 8'h02);
    rd(LT_ADDR_IPEND_SECOND, 8'h80);
    global_irq_enable_i = 0;
    repeat (3) @(negedge clk_i);
    check({6'h00, irq_o, wake_o}, 8'h00);
    wrap_up();
  end
endmodule
